// File: verilog/ibcm_monitor.sv
// Purpose: Start/Stop detection, bus state, address match and collision flags
// Assumes: bus_clk free running and faster than the bus; released lines read high
// Notes: Status built on bus_clk, handed to core_clk through two-flop sync
`default_nettype none
module ibcm_monitor (
    // Core clock domain
    input wire logic core_clk,
    input wire logic rst,
    // Link clock domain
    input wire logic bus_clk,
    input wire logic bus_rst,
    // Bus pins
    input wire ibcm_pkg::ibcm_lines_t lines,
    // Own drive intent on SDA, bus_clk domain
    input wire logic sda_drive_low,
    input wire logic start_request,
    // Configuration, quasi static
    input wire logic [6:0] own_address_register,
    // Status to core, core_clk domain
    output ibcm_pkg::ibcm_status_t status,
    output logic [7:0] rx_byte
);
    import ibcm_pkg::*;

    ibcm_lines_t pin_s;
    logic sda_prev_ff;
    logic scl_prev_ff;
    logic start_det;
    logic stop_det;
    logic scl_low_seen_ff;
    logic bus_active_ff;
    ibcm_slave_t sl_state_ff;
    ibcm_slave_t nxt_sl_state;
    logic [3:0] bit_cnt_ff;
    logic [7:0] shift_ff;
    logic [7:0] rx_byte_ff;
    logic addr_match_ff;
    logic collision_ff;
    logic start_ev_ff;
    logic stop_ev_ff;
    logic [6:0] own_addr_s;
    logic scl_rise;
    logic scl_fall;
    logic [7:0] link_flags;
    logic [7:0] core_flags;
    logic byte_tgl_ff;
    logic byte_tgl_s;
    logic byte_tgl_prev_ff;
    logic [7:0] rx_hold_ff;

    // Pins are asynchronous to everything here
    ibcm_sync #(.WIDTH(2), .INIT(2'h3)) u_pin_sync (
        .clk(bus_clk),
        .rst(bus_rst),
        .d({lines.sda_in, lines.scl_in}),
        .q({pin_s.sda_in, pin_s.scl_in})
    );

    // Address is quasi static; sync keeps each bit clean
    ibcm_sync #(.WIDTH(7), .INIT(IBCM_OWN_ADDR_RST)) u_addr_sync (
        .clk(bus_clk),
        .rst(bus_rst),
        .d(own_address_register),
        .q(own_addr_s)
    );

    always_ff @(posedge bus_clk) begin
        if (bus_rst) begin
            sda_prev_ff <= 1'b1;
            scl_prev_ff <= 1'b1;
        end else begin
            sda_prev_ff <= pin_s.sda_in;
            scl_prev_ff <= pin_s.scl_in;
        end
    end

    assign start_det = sda_prev_ff & ~pin_s.sda_in & scl_prev_ff & pin_s.scl_in;
    // Stop gated by an SCL low period since the Start
    assign stop_det = ~sda_prev_ff & pin_s.sda_in & scl_prev_ff & pin_s.scl_in
                      & scl_low_seen_ff;
    assign scl_rise = ~scl_prev_ff & pin_s.scl_in;
    assign scl_fall = scl_prev_ff & ~pin_s.scl_in;

    always_ff @(posedge bus_clk) begin
        if (bus_rst) begin
            scl_low_seen_ff <= 1'b0;
        end else if (start_det) begin
            scl_low_seen_ff <= 1'b0;
        end else if (~pin_s.scl_in) begin
            scl_low_seen_ff <= 1'b1;
        end
    end

    // Bus state; Active from Start until Stop
    always_ff @(posedge bus_clk) begin
        if (bus_rst) begin
            bus_active_ff <= 1'b0;
        end else if (start_det) begin
            bus_active_ff <= 1'b1;
        end else if (stop_det) begin
            bus_active_ff <= 1'b0;
        end
    end

    // Bit counting on SCL rise; a held-low SCL simply stalls it
    always_ff @(posedge bus_clk) begin
        if (bus_rst) begin
            bit_cnt_ff <= 4'h0;
            shift_ff <= 8'h00;
        end else if (start_det || stop_det) begin
            bit_cnt_ff <= 4'h0;
        end else if (scl_rise) begin
            if (bit_cnt_ff == IBCM_ADDR_BITS) begin
                bit_cnt_ff <= 4'h0; // Ninth clock is the acknowledge slot
            end else begin
                bit_cnt_ff <= bit_cnt_ff + 4'h1;
                shift_ff <= {shift_ff[6:0], pin_s.sda_in};
            end
        end
    end

    logic byte_done;
    assign byte_done = scl_fall && (bit_cnt_ff == IBCM_ADDR_BITS);

    always_comb begin
        nxt_sl_state = sl_state_ff;
        case (sl_state_ff)
            IBCM_SL_IDLE: begin
                if (start_det) begin
                    nxt_sl_state = IBCM_SL_ADDR;
                end
            end
            IBCM_SL_ADDR: begin
                if (byte_done) begin
                    if (shift_ff[7:1] == own_addr_s) begin
                        nxt_sl_state = shift_ff[0] ? IBCM_SL_READ : IBCM_SL_WRITE;
                    end else begin
                        nxt_sl_state = IBCM_SL_IDLE;
                    end
                end
            end
            IBCM_SL_WRITE: nxt_sl_state = sl_state_ff;
            IBCM_SL_READ: nxt_sl_state = sl_state_ff;
            default: nxt_sl_state = IBCM_SL_IDLE;
        endcase
        if (start_det) begin
            nxt_sl_state = IBCM_SL_ADDR;
        end else if (stop_det) begin
            nxt_sl_state = IBCM_SL_IDLE;
        end
    end

    always_ff @(posedge bus_clk) begin
        if (bus_rst) begin
            sl_state_ff <= IBCM_SL_IDLE;
        end else begin
            sl_state_ff <= nxt_sl_state;
        end
    end

    always_ff @(posedge bus_clk) begin
        if (bus_rst) begin
            addr_match_ff <= 1'b0;
            rx_byte_ff <= 8'h00;
        end else begin
            if (start_det || stop_det) begin
                addr_match_ff <= 1'b0;
            end else if (sl_state_ff == IBCM_SL_ADDR && byte_done) begin
                addr_match_ff <= (shift_ff[7:1] == own_addr_s);
            end
            if (byte_done) begin
                rx_byte_ff <= shift_ff;
            end
        end
    end

    // Collision is sticky until a Stop; a fresh collision wins over the clear
    always_ff @(posedge bus_clk) begin
        if (bus_rst) begin
            collision_ff <= 1'b0;
        end else if (start_request && ~pin_s.sda_in) begin
            collision_ff <= 1'b1;
        end else if (~sda_drive_low && ~pin_s.sda_in && pin_s.scl_in && ~start_det
                     && bus_active_ff) begin
            collision_ff <= 1'b1;
        end else if (stop_det) begin
            collision_ff <= 1'b0;
        end
    end

    // Start and Stop held as levels so the core sees them
    always_ff @(posedge bus_clk) begin
        if (bus_rst) begin
            start_ev_ff <= 1'b0;
            stop_ev_ff <= 1'b0;
        end else begin
            if (start_det) begin
                start_ev_ff <= 1'b1;
            end else if (stop_det) begin
                start_ev_ff <= 1'b0;
            end
            if (stop_det) begin
                stop_ev_ff <= 1'b1;
            end else if (start_det) begin
                stop_ev_ff <= 1'b0;
            end
        end
    end

    assign link_flags = {start_ev_ff, stop_ev_ff, bus_active_ff, addr_match_ff,
                         sl_state_ff == IBCM_SL_WRITE, sl_state_ff == IBCM_SL_READ,
                         sl_state_ff == IBCM_SL_WRITE || sl_state_ff == IBCM_SL_READ,
                         collision_ff};

    // Level flags cross as levels; one-cycle skew between bits is tolerated
    ibcm_sync #(.WIDTH(8), .INIT(8'h00)) u_flag_sync (
        .clk(core_clk),
        .rst(rst),
        .d(link_flags),
        .q(core_flags)
    );

    // Toggle marks a new byte; a bitwise sync of the byte itself could tear
    always_ff @(posedge bus_clk) begin
        if (bus_rst) begin
            byte_tgl_ff <= 1'b0;
        end else if (byte_done) begin
            byte_tgl_ff <= ~byte_tgl_ff;
        end
    end

    ibcm_sync #(.WIDTH(1), .INIT(1'b0)) u_byte_sync (
        .clk(core_clk),
        .rst(rst),
        .d(byte_tgl_ff),
        .q(byte_tgl_s)
    );

    // Byte settled long before the toggle lands, and held for a whole byte time
    always_ff @(posedge core_clk) begin
        if (rst) begin
            byte_tgl_prev_ff <= 1'b0;
            rx_hold_ff <= 8'h00;
        end else begin
            byte_tgl_prev_ff <= byte_tgl_s;
            if (byte_tgl_s != byte_tgl_prev_ff) begin
                rx_hold_ff <= rx_byte_ff;
            end
        end
    end

    assign status = core_flags;
    assign rx_byte = rx_hold_ff;
endmodule
`default_nettype wire

// File: verilog/ibcm_pkg.sv
// Purpose: Shared constants and types for the two-wire bus condition monitor
// Assumes: Link clock is the bus sample clock; core side runs at 20 MHz
// Notes: How the block behaves is summarised below
// How it works
// - SDA falling while SCL high is a Start
// - SDA rising while SCL high is a Stop
// - Stop counts only after one SCL low period since the Start
// - Start moves bus state from Idle to Active; masters alone make Starts
// - Idle from reset or a counted Stop until the next Start; else Active
// - Collision when SDA reads low while we release it high, with SCL high on an Active bus
// - Collision when SDA already low before our Start drives it low
// - Address byte compared with own address register; match only on equality
// - Match with R/W clear is a write request; data bytes then clock in
// - Match with R/W set is a read request, held until Restart or Stop
// - Any party may hold SCL low; masters wait for its release
// - Arbitration leaves one master in control at a time
// - Parties driving SCL synchronise their clocks
// - After a match we stay addressed until the transfer ends
// - Restart acts as Start: slave logic resets, expects an address
`default_nettype none
package ibcm_pkg;
    localparam int IBCM_ADDR_W = 7;
    localparam int IBCM_BIT_CNT_W = 4;
    localparam logic [3:0] IBCM_ADDR_BITS = 4'h8;
    localparam logic [6:0] IBCM_OWN_ADDR_RST = 7'h00;
    localparam int IBCM_CLK_HZ = 20000000;
    localparam int IBCM_SYNC_STAGES = 2;

    typedef enum logic [1:0] {
        IBCM_SL_IDLE = 2'b00,
        IBCM_SL_ADDR = 2'b01,
        IBCM_SL_WRITE = 2'b10,
        IBCM_SL_READ = 2'b11
    } ibcm_slave_t;

    typedef struct packed {
        logic start_seen;
        logic stop_seen;
        logic bus_active;
        logic addr_match;
        logic write_req;
        logic read_req;
        logic addressed;
        logic collision;
    } ibcm_status_t;

    typedef struct packed {
        logic sda_in;
        logic scl_in;
    } ibcm_lines_t;
endpackage
`default_nettype wire

// File: verilog/ibcm_sync.sv
// Purpose: Two-flop synchroniser for a bundle of level signals
// Assumes: Destination clock is free running
// Notes: First stage feeds only the second
`default_nettype none
module ibcm_sync #(
    parameter int WIDTH = 2,
    parameter logic [WIDTH-1:0] INIT = '1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Data
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] q_ff;

    always_ff @(posedge clk) begin
        if (rst) begin
            meta_ff <= INIT;
            q_ff <= INIT;
        end else begin
            meta_ff <= d;
            q_ff <= meta_ff;
        end
    end

    assign q = q_ff;
endmodule
`default_nettype wire

// File: test/ibcm_monitor_sva.sv
// Purpose: Status relations of the bus monitor
// Assumes: Bound to ibcm_monitor
// Notes: Core clock domain only
`default_nettype none
module ibcm_monitor_sva (
    // Core clock
    input wire logic core_clk,
    input wire logic rst,
    // Pins and intent
    input wire ibcm_pkg::ibcm_lines_t lines,
    input wire logic sda_drive_low,
    input wire logic start_request,
    // Status
    input wire ibcm_pkg::ibcm_status_t status
);
    import ibcm_pkg::*;
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    // Flag bits cross separately, so related bits may land one cycle apart
    AST_START_ACT: assert property ($rose(status.start_seen) |-> ##1 status.bus_active)
        else $error("start not active");
    AST_STOP_IDLE: assert property ($rose(status.stop_seen) |->
        ##1 (!status.bus_active && !status.start_seen)) else $error("stop not idle");
    AST_IDLE_CLR: assert property (!status.bus_active && !$past(status.bus_active) |->
        !status.addressed && !status.addr_match) else $error("idle but addressed");
    AST_ADDR_ACT: assert property (status.addressed |->
        status.bus_active || $past(status.bus_active)) else $error("addressed while idle");
    AST_WR: assert property ($rose(status.write_req) |->
        ##[0:1] (status.addr_match && !status.read_req)) else $error("bad write request");
    AST_RD: assert property ($rose(status.read_req) |->
        ##[0:1] (status.addr_match && !status.write_req)) else $error("bad read request");
    AST_IDLE_FALL: assert property ($fell(status.bus_active) |-> ##1 status.stop_seen)
        else $error("idle without stop");
    AST_BCOL_START: assert property ((start_request && !sda_drive_low && !lines.sda_in
        && lines.scl_in)[*4] |-> ##[0:6] status.collision) else $error("start collision lost");
    AST_BCOL_HOLD: assert property ($fell(status.collision) |-> ##1 status.stop_seen)
        else $error("collision dropped early");
    cover property ($rose(status.write_req));
    cover property ($rose(status.read_req));
    cover property ($rose(status.collision));
endmodule
bind ibcm_monitor ibcm_monitor_sva u_sva (.core_clk(core_clk), .rst(rst), .lines(lines),
    .sda_drive_low(sda_drive_low), .start_request(start_request), .status(status));
`default_nettype wire

// File: test/ibcm_master_bfm.sv
// Purpose: Two-wire bus master model
// Assumes: Open-drain lines with pull-ups
// Notes: Oe high pulls the line low
`default_nettype none
module ibcm_master_bfm (
    // Drive
    output logic scl_oe,
    output logic sda_oe,
    // Wire level
    input wire logic scl_line
);
    timeunit 1ns;
    timeprecision 100ps;
    localparam int Q = 100;
    initial begin
        scl_oe = 1'b0;
        sda_oe = 1'b0;
    end
    // Release-only drive, so a wire-AND picks one winner
    task automatic put_bit(input logic b);
        sda_oe = !b;
        #Q scl_oe = 1'b0;
        wait (scl_line);
        #Q scl_oe = 1'b1;
        #Q;
    endtask
    task automatic start_c;
        sda_oe = 1'b1;
        #(4*Q) scl_oe = 1'b1;
        #Q;
    endtask
    task automatic restart_c;
        sda_oe = 1'b0;
        #Q scl_oe = 1'b0;
        wait (scl_line);
        #Q start_c;
    endtask
    task automatic stop_c;
        sda_oe = 1'b1;
        #Q scl_oe = 1'b0;
        wait (scl_line);
        #Q sda_oe = 1'b0;
        #Q;
    endtask
    task automatic glitch_c;
        sda_oe = 1'b1;
        #Q sda_oe = 1'b0;
        #Q scl_oe = 1'b1;
        #Q;
    endtask
    task automatic send(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) put_bit(b[i]);
        put_bit(1'b1);
    endtask
endmodule
`default_nettype wire

// File: test/i2c_bus_condition_monitor_test.sv
// Purpose: Self-checking bench for the bus monitor
// Assumes: Master model on the far side, pull-ups
// Notes: Table rows first, awkward cases after
`default_nettype none
module i2c_bus_condition_monitor_test;
    timeunit 1ns;
    timeprecision 100ps;
    import ibcm_pkg::*;
    typedef struct packed {
        logic [6:0] own;
        logic [7:0] b;
        logic m;
        logic w;
        logic r;
    } ibcm_row_t;
    logic core_clk = 1'b0;
    logic bus_clk = 1'b0;
    logic rst = 1'b1;
    logic bus_rst = 1'b1;
    logic sda_drive_low = 1'b0;
    logic start_request = 1'b0;
    logic [6:0] own_addr = 7'h00;
    logic scl_oe;
    logic sda_oe;
    ibcm_lines_t lines;
    ibcm_status_t status;
    logic [7:0] rx_byte;
    ibcm_row_t row;
    int error_cnt = 0;
    int n_checks = 0;
    logic [17:0] rows [6] = '{18'h2D5A6, 18'h2D5AD, 18'h2D5B0, 18'h3FFFD, 18'h0000D, 18'h2D1A0};
    `define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin error_cnt++; \
        $display("[ERR] %s exp %0h got %0h", n, e, g); end end
    always #25 core_clk = ~core_clk;
    // Half-step offset keeps link edges off the core edges
    initial begin
        #0.5;
        forever #3 bus_clk = ~bus_clk;
    end
    assign lines = {!sda_oe && !sda_drive_low, !scl_oe};
    ibcm_monitor dut (.core_clk(core_clk), .rst(rst), .bus_clk(bus_clk), .bus_rst(bus_rst),
        .lines(lines), .sda_drive_low(sda_drive_low), .start_request(start_request),
        .own_address_register(own_addr), .status(status), .rx_byte(rx_byte));
    ibcm_master_bfm m (.scl_oe(scl_oe), .sda_oe(sda_oe), .scl_line(lines.scl_in));
    task automatic gap;
        repeat (8) @(negedge core_clk);
    endtask
    task automatic stop_test;
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        #200000;
        error_cnt++;
        stop_test;
    end
    initial begin
        repeat (5) @(negedge core_clk);
        rst = 1'b0;
        bus_rst = 1'b0;
        gap;
        `CHK("status", 8'h00, status)
        `CHK("rx_byte", 8'h00, rx_byte)
        for (int i = 0; i < 6; i++) begin
            row = rows[i];
            own_addr = row.own;
            m.start_c;
            gap;
            `CHK("start_seen", 1'b1, status.start_seen)
            `CHK("bus_active", 1'b1, status.bus_active)
            m.send(row.b);
            gap;
            `CHK("rx_byte", row.b, rx_byte)
            `CHK("addr_match", row.m, status.addr_match)
            `CHK("write_req", row.w, status.write_req)
            `CHK("read_req", row.r, status.read_req)
            `CHK("addressed", row.m, status.addressed)
            m.stop_c;
            gap;
            `CHK("stop_seen", 1'b1, status.stop_seen)
            `CHK("bus_active", 1'b0, status.bus_active)
            `CHK("addressed", 1'b0, status.addressed)
            $display("row %0d done", i);
        end
        own_addr = 7'h5A;
        m.start_c;
        m.send(8'hB4);
        m.restart_c;
        gap;
        `CHK("write_req", 1'b0, status.write_req)
        `CHK("start_seen", 1'b1, status.start_seen)
        m.send(8'hB5);
        gap;
        `CHK("read_req", 1'b1, status.read_req)
        m.stop_c;
        gap;
        `CHK("read_req", 1'b0, status.read_req)
        $display("restart done");
        m.glitch_c;
        gap;
        `CHK("stop_seen", 1'b0, status.stop_seen)
        `CHK("bus_active", 1'b1, status.bus_active)
        `CHK("collision", 1'b1, status.collision)
        m.stop_c;
        gap;
        `CHK("stop_seen", 1'b1, status.stop_seen)
        $display("glitch done");
        start_request = 1'b1;
        m.start_c;
        gap;
        `CHK("collision", 1'b1, status.collision)
        start_request = 1'b0;
        m.stop_c;
        gap;
        `CHK("collision", 1'b0, status.collision)
        $display("collision done");
        stop_test;
    end
endmodule
`default_nettype wire
